// ===== pmi_pkg.sv
// Purpose: Shared constants and types of the power manager serial command port.
// Assumes: 100 MHz system clock; sub-address map as listed below.
// Notes: Status and mask bits sit at the same positions so they can be combined bit for bit.
package pmi_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_FREQ_HZ = 100_000_000;
    localparam int BUS_MAX_KHZ = 400;
    localparam int HARD_RESET_COMMAND_TIME_MS = 1000;
    localparam int HARD_RESET_COMMAND_CYCLES = (CLK_FREQ_HZ / 1000) * HARD_RESET_COMMAND_TIME_MS;
    localparam int HARD_RESET_COMMAND_CNT_W = 27;

    // ************************************************************
    // Bus addresses and sub-address map
    // ************************************************************
    localparam logic [7:0] DEV_WRITE_ADDR = 8'h78;
    localparam logic [7:0] DEV_READ_ADDR = 8'h79;
    localparam int NUM_CMD_REGS = 22;
    localparam logic [7:0] CMD_FIRST_ADDR = 8'h01;
    localparam logic [7:0] CMD_LAST_ADDR = 8'h16;
    localparam logic [7:0] MASK_ADDR = 8'h16;
    localparam logic [7:0] STATUS_ADDR = 8'h17;
    localparam logic [7:0] CLEAR_ADDR = 8'h18;
    localparam logic [7:0] HARD_RESET_COMMAND_ADDR = 8'h19;
    localparam logic [7:0] CMD_RESET_VALUE = 8'h00;

    // ************************************************************
    // Interrupt status and mask fields
    // ************************************************************
    localparam int IRQ_HARD_RESET_COMMAND_BIT = 1;
    localparam int IRQ_PG_TMO_BIT = 2;
    localparam int IRQ_UV_WARN_BIT = 3;
    localparam int IRQ_UV_FAULT_BIT = 4;
    localparam int IRQ_OT_WARN_BIT = 5;
    localparam int IRQ_OT_FAULT_BIT = 6;
    localparam logic [7:0] MASK_FIELD = 8'h7C;
    localparam logic [7:0] STATUS_FIELD = 8'h7E;
    localparam logic [7:0] MASK_RESET_VALUE = 8'h00;
    localparam logic [7:0] STATUS_RESET_VALUE = 8'h00;

    // ************************************************************
    // Synchroniser layout
    // ************************************************************
    localparam int SYNC_W = 9;
    localparam int SYNC_SCL = 0;
    localparam int SYNC_SDA = 1;
    localparam int SYNC_LSUP = 2;
    localparam int SYNC_PWR = 3;
    localparam int SYNC_EV_LO = 4;
    localparam int NUM_EVENTS = 5;

    typedef enum logic [2:0] {
        PMI_IDLE,
        PMI_RX,
        PMI_ACK,
        PMI_TX,
        PMI_TX_ACK,
        PMI_IGNORE
    } pmi_port_state_type;

    typedef enum logic [1:0] {
        PMI_K_ADDR,
        PMI_K_SUB,
        PMI_K_DATA
    } pmi_byte_kind_type;

    typedef enum logic [1:0] {
        PMI_CS_ACTIVE,
        PMI_CS_STANDBY,
        PMI_CS_HARD_RESET_COMMAND_TIMER,
        PMI_CS_POR
    } pmi_ctrl_state_type;

endpackage

// ===== pmi_sync_filter.sv
// Purpose: Three-stage synchroniser with agreement filter for one asynchronous input.
// Assumes: Input is unrelated to sys_clk.
// Notes: The output only moves when the second and third stages agree.
`timescale 1ns/10ps
`default_nettype none
module pmi_sync_filter #(
    parameter logic RESET_VALUE = 1'b0
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic raw,
    output logic stable
);
    import pmi_pkg::*;

    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic stable;
    } pmi_sync_type;

    pmi_sync_type r;
    pmi_sync_type next_r;

    always_comb begin
        next_r = r;
        next_r.ff1 = raw;
        next_r.ff2 = r.ff1;
        next_r.ff3 = r.ff2;
        if (r.ff2 == r.ff3) begin
            next_r.stable = r.ff3;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            r <= {RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE};
        end else begin
            r <= next_r;
        end
    end

    assign stable = r.stable;

endmodule // pmi_sync_filter
`default_nettype wire

// ===== pmi_command_port.sv
// Purpose: Two-wire slave command port with buffered command registers, interrupt status, mask and hard reset.
// Assumes: SCL and SDA are sampled by sys_clk through filtered synchronisers; fault inputs are levels.
// Notes: Open-drain pins are split into output and output enable, with an input for SDA only; the enable means pull low.
`timescale 1ns/10ps
`default_nettype none
module pmi_command_port #(
    parameter int HARD_RESET_COMMAND_TIMER_CYCLES = pmi_pkg::HARD_RESET_COMMAND_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic irq_out,
    output logic irq_oe,
    input wire logic logic_supply_low,
    input wire logic power_on,
    input wire logic power_good_pin_timeout,
    input wire logic uv_warning,
    input wire logic uv_fault,
    input wire logic ot_warning,
    input wire logic ot_fault,
    output logic [pmi_pkg::NUM_CMD_REGS*8-1:0] command_set,
    output pmi_pkg::pmi_ctrl_state_type controller_state
);
    import pmi_pkg::*;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync_in;

    assign raw_in = {ot_fault, ot_warning, uv_fault, uv_warning, power_good_pin_timeout,
                     power_on, logic_supply_low, sda_in, scl_in};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
            pmi_sync_filter #(
                .RESET_VALUE((gi == SYNC_SCL || gi == SYNC_SDA) ? 1'b1 : 1'b0)
            ) u_sync (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .raw(raw_in[gi]),
                .stable(sync_in[gi])
            );
        end
    endgenerate

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        pmi_port_state_type port;
        pmi_byte_kind_type kind;
        logic [2:0] bit_cnt;
        logic byte_done;
        logic [7:0] shift;
        logic [7:0] pointer;
        logic is_read;
        logic dirty;
        logic clear_pending;
        logic hard_reset_command_pending;
        logic scl_prev;
        logic sda_prev;
        logic [NUM_CMD_REGS-1:0][7:0] shadow;
        logic [NUM_CMD_REGS-1:0][7:0] applied;
        logic [7:0] status;
        logic [NUM_EVENTS-1:0] ev_prev;
        pmi_ctrl_state_type ctrl;
        logic [HARD_RESET_COMMAND_CNT_W-1:0] hard_reset_command_cnt;
        logic sda_oe;
        logic sda_out;
        logic irq_oe;
        logic irq_out;
    } pmi_port_type;

    pmi_port_type r;
    pmi_port_type next_r;

    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [NUM_EVENTS-1:0] ev_level;
    logic [NUM_EVENTS-1:0] ev_rise;
    logic [7:0] read_value;
    logic [7:0] cmd_index;
    logic [7:0] mask_applied;
    logic [7:0] set_bits;

    localparam logic [HARD_RESET_COMMAND_CNT_W-1:0] HARD_RESET_COMMAND_LAST = HARD_RESET_COMMAND_CNT_W'(HARD_RESET_COMMAND_TIMER_CYCLES - 1);

    assign scl_s = sync_in[SYNC_SCL];
    assign sda_s = sync_in[SYNC_SDA];
    // Filtered edges keep short bus glitches from being seen as clocks, within 400kHz timing.
    assign scl_rise = scl_s && !r.scl_prev;
    assign scl_fall = !scl_s && r.scl_prev;
    assign start_seen = scl_s && r.scl_prev && r.sda_prev && !sda_s;
    assign stop_seen = scl_s && r.scl_prev && !r.sda_prev && sda_s;
    assign ev_level = sync_in[SYNC_EV_LO +: NUM_EVENTS];
    assign ev_rise = ev_level & ~r.ev_prev;
    assign cmd_index = r.pointer - CMD_FIRST_ADDR;
    assign mask_applied = r.applied[MASK_ADDR - CMD_FIRST_ADDR] & MASK_FIELD;

    // ************************************************************
    // Read data selection
    // ************************************************************
    always_comb begin
        read_value = 8'h00;
        if (r.pointer >= CMD_FIRST_ADDR && r.pointer <= CMD_LAST_ADDR) begin
            read_value = r.shadow[cmd_index[4:0]];
            if (r.pointer == MASK_ADDR) begin
                read_value = r.shadow[cmd_index[4:0]] & MASK_FIELD;
            end
        end else if (r.pointer == STATUS_ADDR) begin
            read_value = r.status & STATUS_FIELD;
        end
    end

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_r = r;
        set_bits = 8'h00;
        next_r.scl_prev = scl_s;
        next_r.sda_prev = sda_s;
        next_r.ev_prev = ev_level;
        next_r.sda_out = 1'b0;
        next_r.irq_out = 1'b0;

        // Serial port bit engine.
        if (start_seen) begin
            // A repeated START keeps buffered writes and pending commands.
            next_r.port = PMI_RX;
            next_r.kind = PMI_K_ADDR;
            next_r.bit_cnt = 3'd0;
            next_r.byte_done = 1'b0;
            next_r.sda_oe = 1'b0;
        end else if (stop_seen) begin
            next_r.port = PMI_IDLE;
            next_r.sda_oe = 1'b0;
            if (r.dirty) begin
                next_r.applied = r.shadow;
                next_r.dirty = 1'b0;
            end
            next_r.clear_pending = 1'b0;
            next_r.hard_reset_command_pending = 1'b0;
        end else begin
            unique case (r.port)
                PMI_IDLE, PMI_IGNORE: begin
                    next_r.sda_oe = 1'b0;
                end
                PMI_RX: begin
                    if (scl_rise) begin
                        next_r.shift = {r.shift[6:0], sda_s};
                        next_r.bit_cnt = r.bit_cnt + 3'd1;
                        next_r.byte_done = (r.bit_cnt == 3'd7);
                    end else if (scl_fall && r.byte_done) begin
                        next_r.byte_done = 1'b0;
                        next_r.port = PMI_ACK;
                        next_r.sda_oe = 1'b1;
                        unique case (r.kind)
                            PMI_K_ADDR: begin
                                if (r.shift == DEV_WRITE_ADDR) begin
                                    next_r.is_read = 1'b0;
                                    next_r.kind = PMI_K_SUB;
                                end else if (r.shift == DEV_READ_ADDR) begin
                                    next_r.is_read = 1'b1;
                                end else begin
                                    next_r.port = PMI_IGNORE;
                                    next_r.sda_oe = 1'b0;
                                end
                            end
                            PMI_K_SUB: begin
                                next_r.pointer = r.shift;
                                next_r.kind = PMI_K_DATA;
                                if (r.shift == CLEAR_ADDR) begin
                                    next_r.clear_pending = 1'b1;
                                end
                                if (r.shift == HARD_RESET_COMMAND_ADDR) begin
                                    next_r.hard_reset_command_pending = 1'b1;
                                end
                            end
                            PMI_K_DATA: begin
                                // Each data byte is acknowledged; the next byte is a new pointer.
                                next_r.kind = PMI_K_SUB;
                                if (r.pointer >= CMD_FIRST_ADDR && r.pointer <= CMD_LAST_ADDR) begin
                                    next_r.shadow[cmd_index[4:0]] = r.shift;
                                    next_r.dirty = 1'b1;
                                end
                            end
                            default: begin
                                next_r.port = PMI_IGNORE;
                                next_r.sda_oe = 1'b0;
                            end
                        endcase
                    end
                end
                PMI_ACK: begin
                    if (scl_fall) begin
                        next_r.bit_cnt = 3'd0;
                        if (r.is_read) begin
                            next_r.port = PMI_TX;
                            next_r.shift = read_value;
                            next_r.sda_oe = !read_value[7];
                        end else begin
                            next_r.port = PMI_RX;
                            next_r.sda_oe = 1'b0;
                        end
                    end
                end
                PMI_TX: begin
                    if (scl_rise) begin
                        next_r.bit_cnt = r.bit_cnt + 3'd1;
                        next_r.byte_done = (r.bit_cnt == 3'd7);
                    end else if (scl_fall) begin
                        if (r.byte_done) begin
                            next_r.byte_done = 1'b0;
                            next_r.port = PMI_TX_ACK;
                            next_r.sda_oe = 1'b0;
                        end else begin
                            next_r.shift = {r.shift[6:0], 1'b0};
                            next_r.sda_oe = !r.shift[6];
                        end
                    end
                end
                PMI_TX_ACK: begin
                    // The master's answer is not examined, so a missing ack has no effect.
                    if (scl_fall) begin
                        next_r.port = PMI_IGNORE;
                    end
                end
                default: begin
                    next_r.port = PMI_IDLE;
                    next_r.sda_oe = 1'b0;
                end
            endcase
        end

        // Event latching: a masked event still sets its status bit.
        set_bits[IRQ_OT_FAULT_BIT:IRQ_PG_TMO_BIT] = ev_rise;

        // Commands carried by pointer alone act at STOP with the rest of the write.
        if (stop_seen && r.hard_reset_command_pending) begin
            next_r.shadow = {NUM_CMD_REGS{CMD_RESET_VALUE}};
            next_r.applied = {NUM_CMD_REGS{CMD_RESET_VALUE}};
            next_r.dirty = 1'b0;
            set_bits[IRQ_HARD_RESET_COMMAND_BIT] = 1'b1;
        end

        // Status survives hard reset and shutdown; only the clear command empties it.
        // A new event in the clearing cycle wins over the clear.
        if (stop_seen && r.clear_pending) begin
            next_r.status = STATUS_RESET_VALUE | set_bits;
        end else begin
            next_r.status = r.status | set_bits;
        end

        // State controller: faults act whatever the mask says.
        if (stop_seen && r.hard_reset_command_pending) begin
            next_r.ctrl = PMI_CS_HARD_RESET_COMMAND_TIMER;
            next_r.hard_reset_command_cnt = '0;
        end else begin
            unique case (r.ctrl)
                PMI_CS_ACTIVE: begin
                    if (ev_rise[IRQ_UV_FAULT_BIT - IRQ_PG_TMO_BIT] || ev_rise[IRQ_OT_FAULT_BIT - IRQ_PG_TMO_BIT]) begin
                        next_r.ctrl = PMI_CS_STANDBY;
                    end
                end
                PMI_CS_HARD_RESET_COMMAND_TIMER: begin
                    if (r.hard_reset_command_cnt == HARD_RESET_COMMAND_LAST) begin
                        next_r.ctrl = PMI_CS_POR;
                    end else begin
                        next_r.hard_reset_command_cnt = r.hard_reset_command_cnt + 1'b1;
                    end
                end
                PMI_CS_STANDBY, PMI_CS_POR: begin
                    if (sync_in[SYNC_PWR] && !ev_level[IRQ_UV_FAULT_BIT - IRQ_PG_TMO_BIT]
                        && !ev_level[IRQ_OT_FAULT_BIT - IRQ_PG_TMO_BIT]) begin
                        next_r.ctrl = PMI_CS_ACTIVE;
                    end
                end
            endcase
        end

        // Low logic supply wipes the port and the command registers but not the status.
        if (sync_in[SYNC_LSUP]) begin
            next_r.port = PMI_IDLE;
            next_r.kind = PMI_K_ADDR;
            next_r.bit_cnt = 3'd0;
            next_r.byte_done = 1'b0;
            next_r.pointer = 8'h00;
            next_r.is_read = 1'b0;
            next_r.dirty = 1'b0;
            next_r.clear_pending = 1'b0;
            next_r.hard_reset_command_pending = 1'b0;
            next_r.sda_oe = 1'b0;
            next_r.shadow = {NUM_CMD_REGS{CMD_RESET_VALUE}};
            next_r.applied = {NUM_CMD_REGS{CMD_RESET_VALUE}};
        end

        // Pin pulls low for any latched bit whose mask bit is clear.
        next_r.irq_oe = |(next_r.status & STATUS_FIELD & ~mask_applied);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '{port: PMI_IDLE, kind: PMI_K_ADDR, bit_cnt: 3'd0, byte_done: 1'b0, shift: 8'h00,
                   pointer: 8'h00, is_read: 1'b0, dirty: 1'b0, clear_pending: 1'b0,
                   hard_reset_command_pending: 1'b0, scl_prev: 1'b1, sda_prev: 1'b1,
                   shadow: {NUM_CMD_REGS{CMD_RESET_VALUE}}, applied: {NUM_CMD_REGS{CMD_RESET_VALUE}},
                   status: STATUS_RESET_VALUE, ev_prev: '0, ctrl: PMI_CS_POR, hard_reset_command_cnt: '0,
                   sda_oe: 1'b0, sda_out: 1'b0, irq_oe: 1'b0, irq_out: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign sda_out = r.sda_out;
    assign sda_oe = r.sda_oe;
    assign irq_out = r.irq_out;
    assign irq_oe = r.irq_oe;
    assign command_set = r.applied;
    assign controller_state = r.ctrl;

endmodule // pmi_command_port
`default_nettype wire

// ===== pmi_command_port_monitor.sv
// Purpose: Port-level checker for the serial command port.
// Assumes: Sub-address 0x16 is the applied event mask; raw pins reach the logic a few cycles late.
// Notes: Bound into every instance of the port.
`timescale 1ns/10ps
`default_nettype none
module pmi_command_port_monitor #(
    parameter int HARD_RESET_COMMAND_TIMER_CYCLES = pmi_pkg::HARD_RESET_COMMAND_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic irq_out,
    input wire logic irq_oe,
    input wire logic logic_supply_low,
    input wire logic power_on,
    input wire logic power_good_pin_timeout,
    input wire logic uv_warning,
    input wire logic uv_fault,
    input wire logic ot_warning,
    input wire logic ot_fault,
    input wire logic [pmi_pkg::NUM_CMD_REGS*8-1:0] command_set,
    input wire pmi_pkg::pmi_ctrl_state_type controller_state
);
    import pmi_pkg::*;
    logic [4:0] ev_q;
    logic [4:0] ev_rise;
    int unsigned hold_cnt;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    assign ev_rise = {ot_fault, ot_warning, uv_fault, uv_warning, power_good_pin_timeout} & ~ev_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ev_q <= '0;
            hold_cnt <= 0;
        end else begin
            ev_q <= {ot_fault, ot_warning, uv_fault, uv_warning, power_good_pin_timeout};
            hold_cnt <= (controller_state == PMI_CS_HARD_RESET_COMMAND_TIMER) ? hold_cnt + 1 : 0;
        end
    end
    sequence s_hard_reset_command_exit;
        (controller_state == PMI_CS_HARD_RESET_COMMAND_TIMER) ##1 (controller_state != PMI_CS_HARD_RESET_COMMAND_TIMER);
    endsequence
    a_hard_reset_command_exit_por: assert property (s_hard_reset_command_exit |-> controller_state == PMI_CS_POR)
        else $error("hard reset timer did not end in reset state");
    a_hard_reset_command_timer_len: assert property (s_hard_reset_command_exit |-> hold_cnt + 1 >= HARD_RESET_COMMAND_TIMER_CYCLES &&
        hold_cnt <= HARD_RESET_COMMAND_TIMER_CYCLES + 1) else $error("hard reset timer length wrong");
    a_ack_stable_high: assert property ($rose(scl_in) |=> $stable(sda_oe)[*7])
        else $error("data line drive moved while clock high");
    a_fault_standby: assert property (($rose(uv_fault) || $rose(ot_fault)) &&
        controller_state == PMI_CS_ACTIVE |-> ##[1:10] controller_state == PMI_CS_STANDBY)
        else $error("fault did not reach standby");
    a_irq_unmasked: assert property (|(ev_rise & ~command_set[174:170]) |-> ##[2:10] irq_oe)
        else $error("unmasked event did not assert interrupt");
    a_irq_fell_stop: assert property ($fell(irq_oe) |-> scl_in && sda_in)
        else $error("interrupt released outside a stop");
    a_cmd_at_stop: assert property (!$stable(command_set) |-> (scl_in && sda_in) || logic_supply_low)
        else $error("command set changed outside a stop");
    a_supply_clear: assert property (logic_supply_low[*8] |-> command_set == '0 && !sda_oe)
        else $error("low logic supply did not clear port");
    a_open_drain_zero: assert property (sda_out == 1'b0 && irq_out == 1'b0)
        else $error("open drain drive value not low");
endmodule // pmi_command_port_monitor
bind pmi_command_port pmi_command_port_monitor #(.HARD_RESET_COMMAND_TIMER_CYCLES(HARD_RESET_COMMAND_TIMER_CYCLES)) i_mon (
    .sys_clk(sys_clk), .rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq_out(irq_out), .irq_oe(irq_oe), .logic_supply_low(logic_supply_low),
    .power_on(power_on), .power_good_pin_timeout(power_good_pin_timeout), .uv_warning(uv_warning), .uv_fault(uv_fault),
    .ot_warning(ot_warning), .ot_fault(ot_fault), .command_set(command_set),
    .controller_state(controller_state));
`default_nettype wire

// ===== pmi_i2c_master.sv
// Purpose: Behavioural two-wire bus master that drives the command port.
// Assumes: Pull-ups on both lines; the master never stretches or shares the clock.
// Notes: Each bit is 8 cycles low and 8 high, a 160 ns bus period.
`timescale 1ns/10ps
`default_nettype none
module pmi_i2c_master (
    input wire logic sys_clk,
    output logic scl,
    output logic sda_low,
    input wire logic sda_line
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Data moves well after the clock falls so the filtered clock is low before data changes.
    task automatic bit_cycle(input logic v, output logic r);
        w(5);
        sda_low = !v;
        w(3);
        scl = 1'b1;
        w(8);
        r = sda_line;
        scl = 1'b0;
    endtask
    task automatic start();
        w(5);
        sda_low = 1'b0;
        w(3);
        scl = 1'b1;
        w(8);
        sda_low = 1'b1;
        w(8);
        scl = 1'b0;
    endtask
    task automatic stop();
        w(5);
        sda_low = 1'b1;
        w(3);
        scl = 1'b1;
        w(8);
        sda_low = 1'b0;
        w(8);
    endtask
    task automatic put(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_cycle(b[i], r);
        bit_cycle(1'b1, r);
        ack = !r;
    endtask
    task automatic get(output logic [7:0] b, input logic m_ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_cycle(1'b1, b[i]);
        bit_cycle(!m_ack, r);
    endtask
endmodule // pmi_i2c_master
`default_nettype wire

// ===== pmi_command_port_test.sv
// Purpose: Self-checking bench for the serial command port.
// Assumes: Hard reset timer shortened to 20 cycles.
// Notes: Table rows cover plain writes and read-back; odd cases follow by hand.
`timescale 1ns/10ps
`default_nettype none
module pmi_command_port_test;
    import pmi_pkg::*;
    typedef struct {logic [7:0] ptr; logic [7:0] data; logic [7:0] rdback;} pmi_row_type;
    localparam int HT = 20;
    logic sys_clk;
    logic rstn;
    logic scl;
    logic m_low;
    logic sda_oe;
    logic irq_oe;
    logic supply_low;
    logic power_on;
    logic [4:0] ev;
    logic [NUM_CMD_REGS*8-1:0] cmd;
    pmi_ctrl_state_type state;
    logic ack;
    logic [7:0] rd_val;
    int n_fail = 0;
    int samples_checked = 0;
    int cyc = 0;
    wire sda_line = !(m_low || sda_oe);
    pmi_row_type rows [4] = '{'{8'h01, 8'hA5, 8'hA5}, '{8'h0B, 8'h3C, 8'h3C}, '{8'h15, 8'hFF, 8'hFF},
        '{8'h16, 8'h80, 8'h00}};
    pmi_command_port #(.HARD_RESET_COMMAND_TIMER_CYCLES(HT)) i_dut (
        .sys_clk(sys_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe),
        .irq_out(), .irq_oe(irq_oe), .logic_supply_low(supply_low), .power_on(power_on),
        .power_good_pin_timeout(ev[0]), .uv_warning(ev[1]), .uv_fault(ev[2]), .ot_warning(ev[3]), .ot_fault(ev[4]),
        .command_set(cmd), .controller_state(state));
    pmi_i2c_master i_m (.sys_clk(sys_clk), .scl(scl), .sda_low(m_low), .sda_line(sda_line));
    always #5 sys_clk = ~sys_clk;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [175:0] got, input logic [175:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic with_d);
        i_m.start();
        i_m.put(DEV_WRITE_ADDR, ack);
        chk(ack, 1'b1);
        i_m.put(p, ack);
        if (with_d) i_m.put(d, ack);
        chk(ack, 1'b1);
        i_m.stop();
    endtask
    task automatic rd(input logic [7:0] p, input logic send_p, output logic [7:0] d);
        if (send_p) begin
            i_m.start();
            i_m.put(DEV_WRITE_ADDR, ack);
            i_m.put(p, ack);
        end
        i_m.start();
        i_m.put(DEV_READ_ADDR, ack);
        chk(ack, 1'b1);
        i_m.get(d, 1'b0);
        i_m.stop();
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        supply_low = 1'b0;
        power_on = 1'b1;
        ev = '0;
        repeat (4) @(posedge sys_clk);
        #1 rstn = 1'b1;
        i_m.w(6);
        rd(MASK_ADDR, 1'b1, rd_val);
        chk(rd_val, MASK_RESET_VALUE);
        $display("done: reset");
        foreach (rows[i]) begin
            wr(rows[i].ptr, rows[i].data, 1'b1);
            if (rows[i].ptr != MASK_ADDR) chk(cmd[8*(int'(rows[i].ptr)-1) +: 8], rows[i].data);
            rd(rows[i].ptr, 1'b1, rd_val);
            chk(rd_val, rows[i].rdback);
        end
        $display("done: table");
        i_m.start();
        i_m.put(DEV_WRITE_ADDR, ack);
        i_m.put(8'h01, ack);
        i_m.put(8'h11, ack);
        i_m.put(8'h05, ack);
        i_m.put(8'h22, ack);
        i_m.start();
        i_m.put(DEV_WRITE_ADDR, ack);
        i_m.put(8'h02, ack);
        i_m.put(8'h33, ack);
        chk(cmd[7:0], 8'hA5);
        i_m.stop();
        chk({cmd[39:32], cmd[15:0]}, 24'h22_3311);
        rd(8'h00, 1'b0, rd_val);
        chk(rd_val, 8'h33);
        i_m.start();
        i_m.put(8'h7A, ack);
        chk(ack, 1'b0);
        i_m.stop();
        $display("done: bus");
        for (int i = 0; i < 5; i++) begin
            ev = 5'h01 << i;
            i_m.w(12);
            chk(irq_oe, 1'b1);
            rd(STATUS_ADDR, 1'b1, rd_val);
            chk(rd_val, 8'h01 << (i + 2));
            ev = 5'h00;
            wr(CLEAR_ADDR, 8'h00, 1'b0);
            chk(irq_oe, 1'b0);
        end
        wr(MASK_ADDR, 8'h7C, 1'b1);
        ev = 5'h04;
        i_m.w(12);
        chk(irq_oe, 1'b0);
        chk(state, PMI_CS_STANDBY);
        rd(STATUS_ADDR, 1'b1, rd_val);
        chk(rd_val, 8'h10);
        ev = 5'h00;
        wr(CLEAR_ADDR, 8'h00, 1'b0);
        $display("done: events");
        // With no wake request the controller must rest in the reset state once the timer ends.
        power_on = 1'b0;
        wr(HARD_RESET_COMMAND_ADDR, 8'h00, 1'b0);
        chk(cmd, '0);
        chk(state, PMI_CS_HARD_RESET_COMMAND_TIMER);
        for (int n = 0; n < 40 && state == PMI_CS_HARD_RESET_COMMAND_TIMER; n++) i_m.w(1);
        chk(state, PMI_CS_POR);
        i_m.w(12);
        chk(state, PMI_CS_POR);
        power_on = 1'b1;
        i_m.w(8);
        chk(state, PMI_CS_ACTIVE);
        chk(irq_oe, 1'b1);
        rd(STATUS_ADDR, 1'b1, rd_val);
        chk(rd_val, 8'h02);
        $display("done: hard reset");
        wr(8'h01, 8'h5A, 1'b1);
        supply_low = 1'b1;
        i_m.w(10);
        chk(cmd, '0);
        supply_low = 1'b0;
        i_m.w(6);
        $display("done: supply");
        print_verdict();
    end
endmodule // pmi_command_port_test
`default_nettype wire
